// ===== dv/pmtr_core_model.sv
// pmtr_core_model: core side issuing one table read at a time.
// assumes the block answers with a done pulse and a write-back word.
module pmtr_core_model (
	// clock
	input wire logic clock,
	// answer
	input wire logic tr_done_ff,
	input wire pmtr_pkg::pmtr_wb_s tr_wb_ff,
	// request
	output logic tr_start,
	output pmtr_pkg::pmtr_req_s tr_req
);
	timeunit 1ns;
	timeprecision 100ps;
	import pmtr_pkg::*;
	initial begin
		tr_start = 1'b0;
		tr_req = '0;
	end
	// request lines scrambled once taken, so a late sample shows up
	task automatic rd(input pmtr_req_s r, output pmtr_wb_s wb, output int n);
		tr_req = r;
		tr_start = 1'b1;
		@(posedge clock);
		#1;
		tr_start = 1'b0;
		tr_req = pmtr_req_s'(~r);
		n = 0;
		while (!tr_done_ff && n < 20) begin
			@(posedge clock);
			#1;
			n++;
		end
		wb = tr_wb_ff;
	endtask : rd
endmodule : pmtr_core_model

// ===== dv/pmtr_top_monitor.sv
// pmtr_top_monitor: timing checks on table-read, holding and pin ports.
// assumes it is bound to pmtr_top and sees that module's port names.
module pmtr_top_monitor (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// watched ports
	input wire logic tr_start,
	input wire logic prog_mode,
	input wire logic tr_busy_ff,
	input wire logic tr_done_ff,
	input wire logic hold_wr,
	input wire logic [7:0] hold_wdata,
	input wire logic [7:0] table_high_holding_ff,
	input wire logic emu_variant,
	input wire logic pin_func_enable_ff,
	input wire logic prog_serial_data_oe_n_ff
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	AST_DONE_LAT: assert property (tr_start && !tr_busy_ff && !prog_mode |-> ##3 tr_done_ff)
		else $error("table read not done on third edge");
	AST_BUSY_SPAN: assert property (tr_start && !tr_busy_ff && !prog_mode
		|=> tr_busy_ff [*2] ##1 !tr_busy_ff) else $error("busy span wrong");
	AST_DONE_PULSE: assert property (tr_done_ff |=> !tr_done_ff)
		else $error("done longer than one cycle");
	AST_DONE_CAUSE: assert property (!tr_busy_ff |=> !tr_done_ff)
		else $error("done without a read in flight");
	AST_HOLD_WR: assert property (hold_wr && !tr_busy_ff
		|=> table_high_holding_ff == $past(hold_wdata)) else $error("holding write lost");
	AST_HOLD_KEEP: assert property (!hold_wr && !tr_busy_ff
		|=> $stable(table_high_holding_ff)) else $error("holding changed alone");
	AST_EMU_PINS: assert property (emu_variant ##1 emu_variant |-> !pin_func_enable_ff)
		else $error("shared pin functions active on emulation part");
	// pin enable passes two flops, so release shows on the third edge
	AST_OE_IDLE: assert property (!prog_mode ##1 !prog_mode ##1 !prog_mode |-> prog_serial_data_oe_n_ff)
		else $error("data pin driven outside programming");
endmodule : pmtr_top_monitor

bind pmtr_top pmtr_top_monitor u_mon (.clock(clock), .rst(rst), .tr_start(tr_start),
	.prog_mode(prog_mode), .tr_busy_ff(tr_busy_ff), .tr_done_ff(tr_done_ff),
	.hold_wr(hold_wr), .hold_wdata(hold_wdata), .table_high_holding_ff(table_high_holding_ff),
	.emu_variant(emu_variant), .pin_func_enable_ff(pin_func_enable_ff),
	.prog_serial_data_oe_n_ff(prog_serial_data_oe_n_ff));

// ===== dv/tb.sv
// tb: drives the program store block through core, serial and pin ports.
// assumes the core model issues table reads and the bench plays programmer.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import pmtr_pkg::*;
	logic clock = 1'b0, rst = 1'b1, fetch_en = 1'b0, hold_wr = 1'b0;
	logic emu = 1'b0, prog = 1'b0, sclk = 1'b0, sdat = 1'b0;
	logic [12:0] faddr = 13'h0155;
	logic [7:0] hwd = 8'h00;
	logic tr_start, done, err, pin_en, sout, soe_n;
	logic [12:0] pc;
	logic [15:0] fword;
	logic [7:0] hold;
	pmtr_req_s req;
	pmtr_wb_s wb;
	int num_errors = 0, checks = 0;
	wire pin = soe_n ? sdat : sout;
	initial forever #2.5 clock = ~clock;
	pmtr_top uut (.clock(clock), .rst(rst), .fetch_en(fetch_en), .fetch_addr(faddr),
		.fetch_pc_ff(pc), .fetch_word_ff(fword), .tr_start(tr_start), .tr_req(req),
		.tr_busy_ff(), .tr_done_ff(done), .tr_sector_err_ff(err), .tr_wb_ff(wb),
		.hold_wr(hold_wr), .hold_wdata(hwd), .table_high_holding_ff(hold), .emu_variant(emu),
		.prog_mode(prog), .prog_serial_clock(sclk & !emu), .prog_serial_data_in(pin & !emu),
		.prog_serial_data_out_ff(sout), .prog_serial_data_oe_n_ff(soe_n),
		.debug_serial_clock(sclk & emu), .debug_serial_data_in(pin & emu),
		.pin_func_enable_ff(pin_en));
	pmtr_core_model u_core (.clock(clock), .tr_done_ff(done), .tr_wb_ff(wb),
		.tr_start(tr_start), .tr_req(req));
	task check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task stop_test();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test
	task tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick
	// serial clock stands low between frames
	task ser(input logic rd, input logic [12:0] a, input logic [15:0] d, output logic [15:0] q);
		logic [29:0] f;
		f = {rd, a, d};
		for (int i = 29; i >= 0; i--) begin
			sdat = f[i];
			tick(4);
			q = {q[14:0], pin};
			if (i == 0) check(soe_n, !rd);
			sclk = 1'b1;
			tick(4);
			sclk = 1'b0;
		end
		sdat = ~sdat;
		tick(4);
	endtask : ser
	task t_serial();
		logic [15:0] q;
		prog = 1'b1;
		ser(1'b0, 13'h0106, 16'h5A3C, q);
		ser(1'b0, 13'h0000, 16'h3C5A, q);
		ser(1'b0, 13'h1F06, 16'hA51A, q);
		ser(1'b1, 13'h1F06, 16'h0000, q);
		check(q, 16'hA51A);
		emu = 1'b1;
		ser(1'b0, 13'h1F07, 16'h0C33, q);
		check(pin_en, 1'b0);
		emu = 1'b0;
		prog = 1'b0;
		tick(2);
		check(pin_en, 1'b1);
		$display("serial test done");
	endtask : t_serial
	// back to back: each start lands on the previous done cycle
	task automatic t_table();
		// last entry: basic form outside sector zero, flagged but data still returned
		pmtr_op_e op [6] = '{PMTR_TR_STD, PMTR_TR_LAST, PMTR_TR_EXT_FULL, PMTR_TR_EXT_LAST,
			PMTR_TR_EXT_FULL, PMTR_TR_STD};
		logic [7:0] hi [6] = '{8'hE1, 8'h00, 8'h1F, 8'h42, 8'hFF, 8'h1F};
		logic [15:0] ex [6] = '{16'h5A3C, 16'hA51A, 16'hA51A, 16'hA51A, 16'h0C33, 16'h0C33};
		pmtr_wb_s w;
		int n;
		for (int i = 0; i < 6; i++) begin
			u_core.rd(pmtr_req_s'({op[i], 8'h06 + 8'(i / 4), hi[i], 8'h30 + 8'(i)}), w, n);
			check(16'(n), 16'(PMTR_OP_CYCLES));
			check(w.data, ex[i][7:0]);
			check(w.dest, 8'h30 + 8'(i));
			check(hold, ex[i][15:8]);
			check(err, 16'(i == 5));
			if (n > 9) stop_test();
		end
		$display("table test done");
	endtask : t_table
	task t_hold();
		hwd = 8'hC7;
		hold_wr = 1'b1;
		tick(1);
		hold_wr = 1'b0;
		tick(1);
		check(hold, 8'hC7);
		$display("holding test done");
	endtask : t_hold
	task t_fetch();
		faddr = 13'h0106;
		fetch_en = 1'b1;
		tick(3);
		check(pc, 13'h0106);
		check(fword, 16'h5A3C);
		faddr = 13'h1F06;
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		tick(1);
		check(pc, 13'h0000);
		tick(1);
		check(pc, 13'h1F06);
		check(fword, 16'h3C5A);
		$display("fetch test done");
	endtask : t_fetch
	initial begin
		tick(3);
		rst = 1'b0;
		t_serial();
		t_table();
		t_hold();
		t_fetch();
		stop_test();
	end
endmodule : tb

// ===== src/pmtr_pkg.sv
// pmtr_pkg: shared constants and carrier types for the program memory table-read block.
// assumes a single 200 MHz clock domain and a core that issues one table op at a time.
package pmtr_pkg;
	localparam int PMTR_AW = 13;
	localparam int PMTR_DW = 16;
	localparam int PMTR_DEPTH = 8192;
	localparam logic [PMTR_AW-1:0] PMTR_RESET_VEC = 13'h0000;
	localparam logic [PMTR_AW-1:0] PMTR_LAST_PAGE = 13'h1F00;
	localparam logic [PMTR_AW-1:0] PMTR_SECTOR_MASK = 13'h1F00;
	localparam logic [PMTR_AW-1:0] PMTR_SECTOR0_END = 13'h0FFF;
	localparam logic [PMTR_AW-1:0] PMTR_ONE_VEC = 13'h0001;
	localparam logic [1:0] PMTR_OP_CYCLES = 2'h2;
	localparam logic [7:0] PMTR_BYTE_ZERO = 8'h00;
	localparam logic [15:0] PMTR_WORD_ZERO = 16'h0000;
	localparam logic [4:0] PMTR_SHIFT_BITS = 5'h10;
	localparam logic [4:0] PMTR_SHIFT_ZERO = 5'h00;

	// table read flavours issued by the core
	typedef enum logic [1:0] {
		PMTR_TR_STD,
		PMTR_TR_LAST,
		PMTR_TR_EXT_FULL,
		PMTR_TR_EXT_LAST
	} pmtr_op_e;

	typedef struct packed {
		pmtr_op_e op;
		logic [7:0] ptr_lo;
		logic [7:0] ptr_hi;
		logic [7:0] dest;
	} pmtr_req_s;

	typedef struct packed {
		logic [7:0] dest;
		logic [7:0] data;
	} pmtr_wb_s;
endpackage : pmtr_pkg

// ===== src/pmtr_serial.sv
// pmtr_serial: serial programming shifter on one data pin plus an external clock line.
// assumes the programmer clock is slow and synchronous to clock; frames are dir bit + 13 addr + 16 data.
module pmtr_serial (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// pins
	input wire logic ser_clk,
	input wire logic ser_data_in,
	output logic ser_data_out_ff,
	output logic ser_data_oe_n_ff,
	// store access
	input wire logic enable,
	input wire logic [pmtr_pkg::PMTR_DW-1:0] rd_word,
	output logic wr_pulse_ff,
	output logic [pmtr_pkg::PMTR_AW-1:0] addr_ff,
	output logic [pmtr_pkg::PMTR_DW-1:0] wdata_ff
);
	import pmtr_pkg::*;

	logic clk_prev_ff;
	logic rise;
	logic fall;
	logic [4:0] bit_cnt_ff;
	logic phase_addr_ff;
	logic read_dir_ff;
	logic [PMTR_DW-1:0] out_sr_ff;

	assign rise = enable & ser_clk & ~clk_prev_ff;
	assign fall = enable & ~ser_clk & clk_prev_ff;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			clk_prev_ff <= 1'b0;
		end else begin
			clk_prev_ff <= ser_clk;
		end
	end

	// frame: dir bit, 13 address bits, then 16 data bits in or out, msb first
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bit_cnt_ff <= PMTR_SHIFT_ZERO;
			phase_addr_ff <= 1'b1;
			read_dir_ff <= 1'b0;
			addr_ff <= PMTR_RESET_VEC;
			wdata_ff <= PMTR_WORD_ZERO;
			wr_pulse_ff <= 1'b0;
		end else begin
			wr_pulse_ff <= 1'b0;
			if (!enable) begin
				bit_cnt_ff <= PMTR_SHIFT_ZERO;
				phase_addr_ff <= 1'b1;
			end else if (rise) begin
				bit_cnt_ff <= bit_cnt_ff + 5'h01;
				if (phase_addr_ff) begin
					if (bit_cnt_ff == PMTR_SHIFT_ZERO) begin
						read_dir_ff <= ser_data_in;
					end else begin
						addr_ff <= {addr_ff[PMTR_AW-2:0], ser_data_in};
					end
					if (bit_cnt_ff == 5'(PMTR_AW)) begin
						phase_addr_ff <= 1'b0;
						bit_cnt_ff <= PMTR_SHIFT_ZERO;
					end
				end else begin
					wdata_ff <= {wdata_ff[PMTR_DW-2:0], ser_data_in};
					if (bit_cnt_ff == PMTR_SHIFT_BITS - 5'h01) begin
						wr_pulse_ff <= ~read_dir_ff; // RULE9
						phase_addr_ff <= 1'b1;
						bit_cnt_ff <= PMTR_SHIFT_ZERO;
					end
				end
			end
		end
	end

	// upload: pin driven only in the data phase of a read frame
	// word taken at the first data fall, not the last address rise: the store
	// needs the full address a cycle before it answers, so the programmer must
	// leave at least two clocks between the last address rise and that fall
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			out_sr_ff <= PMTR_WORD_ZERO;
			ser_data_out_ff <= 1'b0;
			ser_data_oe_n_ff <= 1'b1;
		end else begin
			if (fall && !phase_addr_ff) begin
				if (bit_cnt_ff == PMTR_SHIFT_ZERO) begin
					out_sr_ff <= {rd_word[PMTR_DW-2:0], 1'b0};
					ser_data_out_ff <= rd_word[PMTR_DW-1]; // RULE9
				end else begin
					out_sr_ff <= {out_sr_ff[PMTR_DW-2:0], 1'b0};
					ser_data_out_ff <= out_sr_ff[PMTR_DW-1]; // RULE9
				end
			end
			ser_data_oe_n_ff <= ~(enable & read_dir_ff & ~phase_addr_ff);
		end
	end
endmodule : pmtr_serial

// ===== src/pmtr_store.sv
// pmtr_store: 8K x 16 program store in flip-flops, one read port, one write port.
// assumes reads and writes are single-cycle and issued by the parent only.
module pmtr_store (
	// clock
	input wire logic clock,
	// read port
	input wire logic [pmtr_pkg::PMTR_AW-1:0] rd_addr,
	output logic [pmtr_pkg::PMTR_DW-1:0] rd_data_ff,
	// write port
	input wire logic wr_en,
	input wire logic [pmtr_pkg::PMTR_AW-1:0] wr_addr,
	input wire logic [pmtr_pkg::PMTR_DW-1:0] wr_data
);
	import pmtr_pkg::*;

	logic [PMTR_DW-1:0] mem [PMTR_DEPTH];

	// no reset on storage: contents are nonvolatile program data
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clock) begin
		rd_data_ff <= mem[rd_addr];
	end
endmodule : pmtr_store

// ===== src/pmtr_top.sv
// pmtr_top: program store, fetch after reset, table reads and serial programming port.
// assumes the core presents a request with its start pulse and honours the two-cycle table timing.
// Behaviour
// [RULE1] program store is 8K words of 16 bits, for fetch and tables
// [RULE2] fetch starts at word zero after every reset
// [RULE3] standard table read address is high pointer byte then low byte
// [RULE4] low byte goes to named data register, high byte to holding register
// [RULE5] last-page reads use 1F00 plus low pointer byte
// [RULE6] every table instruction takes exactly two instruction cycles
// [RULE7] basic forms serve sector zero, extended forms any sector
// [RULE8] holding register is readable and writable by software
// [RULE9] programmer moves data both ways over one pin with its clock
// [RULE10] on emulation part debug pins still serve as programming pins
// [RULE11] only thirteen address bits used, upper pointer bits ignored
module pmtr_top (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// instruction fetch
	input wire logic fetch_en,
	input wire logic [pmtr_pkg::PMTR_AW-1:0] fetch_addr,
	output logic [pmtr_pkg::PMTR_AW-1:0] fetch_pc_ff,
	output logic [pmtr_pkg::PMTR_DW-1:0] fetch_word_ff,
	// table read request from the core
	input wire logic tr_start,
	input wire pmtr_pkg::pmtr_req_s tr_req,
	output logic tr_busy_ff,
	output logic tr_done_ff,
	output logic tr_sector_err_ff,
	output pmtr_pkg::pmtr_wb_s tr_wb_ff,
	// holding register software access
	input wire logic hold_wr,
	input wire logic [7:0] hold_wdata,
	output logic [7:0] table_high_holding_ff,
	// serial programming and debug pins
	input wire logic emu_variant,
	input wire logic prog_mode,
	input wire logic prog_serial_clock,
	input wire logic prog_serial_data_in,
	output logic prog_serial_data_out_ff,
	output logic prog_serial_data_oe_n_ff,
	input wire logic debug_serial_clock,
	input wire logic debug_serial_data_in,
	output logic pin_func_enable_ff
);
	import pmtr_pkg::*;

	typedef enum logic [1:0] {
		PMTR_ST_IDLE,
		PMTR_ST_ADDR,
		PMTR_ST_DATA
	} pmtr_state_e;

	pmtr_state_e state_ff;
	pmtr_req_s req_ff;
	logic [PMTR_AW-1:0] tbl_addr;
	logic [PMTR_AW-1:0] rd_addr;
	logic [PMTR_DW-1:0] rd_data;
	logic [PMTR_DW-1:0] ser_dummy;
	logic [1:0] cyc_ff;
	logic ser_clk_mux;
	logic ser_din_mux;
	logic ser_en;
	logic ser_wr;
	logic [PMTR_AW-1:0] ser_addr;
	logic [PMTR_DW-1:0] ser_wdata;
	logic ser_out;
	logic ser_oe_n;
	logic basic_form;
	logic out_of_sector0;
	logic fetch_started_ff;

	// PMTR_TR_STD and PMTR_TR_EXT_FULL reach all 13 bits; unused high pointer bits are dropped
	always_comb begin
		unique case (req_ff.op)
			PMTR_TR_STD, PMTR_TR_EXT_FULL: begin
				tbl_addr = {req_ff.ptr_hi[PMTR_AW-9:0], req_ff.ptr_lo}; // RULE3 RULE11
			end
			PMTR_TR_LAST, PMTR_TR_EXT_LAST: begin
				tbl_addr = PMTR_LAST_PAGE | {5'h00, req_ff.ptr_lo}; // RULE5
			end
		endcase
	end

	assign basic_form = (req_ff.op == PMTR_TR_STD);
	assign out_of_sector0 = (tbl_addr > PMTR_SECTOR0_END);

	// debug pins take over the programming port on the emulation part
	assign ser_clk_mux = emu_variant ? debug_serial_clock : prog_serial_clock; // RULE10
	assign ser_din_mux = emu_variant ? debug_serial_data_in : prog_serial_data_in; // RULE10
	assign ser_en = prog_mode;

	// table read owns the port in its address cycle, then serial, then fetch
	always_comb begin
		if (state_ff == PMTR_ST_ADDR) begin
			rd_addr = tbl_addr;
		end else if (ser_en) begin
			rd_addr = ser_addr;
		end else if (!fetch_started_ff) begin
			rd_addr = PMTR_RESET_VEC; // RULE2
		end else begin
			rd_addr = fetch_addr;
		end
	end

	pmtr_store u_store (
		.clock(clock),
		.rd_addr(rd_addr),
		.rd_data_ff(rd_data),
		.wr_en(ser_wr),
		.wr_addr(ser_addr),
		.wr_data(ser_wdata)
	); // RULE1

	pmtr_serial u_serial (
		.clock(clock),
		.rst(rst),
		.ser_clk(ser_clk_mux),
		.ser_data_in(ser_din_mux),
		.ser_data_out_ff(ser_out),
		.ser_data_oe_n_ff(ser_oe_n),
		.enable(ser_en),
		.rd_word(rd_data),
		.wr_pulse_ff(ser_wr),
		.addr_ff(ser_addr),
		.wdata_ff(ser_wdata)
	); // RULE9

	assign ser_dummy = rd_data;

	// pins pass through one more flop so every output is registered
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prog_serial_data_out_ff <= 1'b0;
			prog_serial_data_oe_n_ff <= 1'b1;
			pin_func_enable_ff <= 1'b1;
		end else begin
			prog_serial_data_out_ff <= ser_out;
			prog_serial_data_oe_n_ff <= ser_oe_n;
			pin_func_enable_ff <= ~emu_variant; // RULE10
		end
	end

	// fetch: first fetch after reset is forced to the reset vector
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fetch_started_ff <= 1'b0;
			fetch_pc_ff <= PMTR_RESET_VEC; // RULE2
			fetch_word_ff <= PMTR_WORD_ZERO;
		end else begin
			if (fetch_en && state_ff == PMTR_ST_IDLE && !ser_en) begin
				fetch_started_ff <= 1'b1;
				fetch_pc_ff <= rd_addr;
			end
			fetch_word_ff <= ser_dummy;
		end
	end

	// table read sequencer: address cycle then data cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_ff <= PMTR_ST_IDLE;
			req_ff <= '0;
			cyc_ff <= 2'h0;
			tr_busy_ff <= 1'b0;
			tr_done_ff <= 1'b0;
		end else begin
			tr_done_ff <= 1'b0;
			unique case (state_ff)
				PMTR_ST_IDLE: begin
					if (tr_start && !ser_en) begin
						req_ff <= tr_start ? tr_req : req_ff;
						state_ff <= PMTR_ST_ADDR;
						tr_busy_ff <= 1'b1;
						cyc_ff <= 2'h1;
					end
				end
				PMTR_ST_ADDR: begin
					state_ff <= PMTR_ST_DATA;
					cyc_ff <= cyc_ff + 2'h1;
				end
				PMTR_ST_DATA: begin
					if (cyc_ff == PMTR_OP_CYCLES) begin
						state_ff <= PMTR_ST_IDLE;
						tr_busy_ff <= 1'b0;
						tr_done_ff <= 1'b1; // RULE6
						cyc_ff <= 2'h0;
					end
				end
			endcase
		end
	end

	// results: low byte to destination, high byte to holding register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tr_wb_ff <= '0;
			tr_sector_err_ff <= 1'b0;
		end else if (state_ff == PMTR_ST_DATA) begin
			tr_wb_ff.dest <= req_ff.dest; // RULE4
			tr_wb_ff.data <= rd_data[7:0]; // RULE4
			// basic form outside sector zero flagged, data still returned
			tr_sector_err_ff <= basic_form & out_of_sector0; // RULE7
		end
	end

	// table completion wins over a same-cycle software write
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			table_high_holding_ff <= PMTR_BYTE_ZERO;
		end else if (state_ff == PMTR_ST_DATA) begin
			table_high_holding_ff <= rd_data[15:8]; // RULE4
		end else if (hold_wr) begin
			table_high_holding_ff <= hold_wdata; // RULE8
		end
	end
endmodule : pmtr_top
